// [hdl/dcd_host.sv]
// Overview of operation
// - Drive-ready test is class 0 opcode 00, drive bit in byte 1.
// - Recalibrate is class 0 opcode 01, drive in byte 1, step and retry in byte 5.
// - Class 0 opcode 02 is reserved and never sent.
// - Sense status is class 0 opcode 03 for the drive in byte 1.
// - Format drive, opcode 04, carries head, cylinder, interleave and byte 5 options.
// - Verify, opcode 05, carries head, cylinder, block count, retry and reread bits.
// - Format byte 4 keeps top two bits zero, interleave 1 to 16.
// - Read 08 and write 0A carry cylinder high, sector, cylinder low, count.
// - Seek and format clear the sector bits; seek byte 4 is ignored.
// - Byte 1 holds two zero bits, the drive bit, then five head bits.
// - Class 0 opcode 09 is unassigned and never sent.
// - Opcode 0C loads drive characteristics; bytes 1 to 5 are ignored.
// - Opcode 0C is followed by exactly eight parameter bytes.
// - Parameters: max cylinders, max heads, reduced-current, precomp, ECC burst.
// - Class 7 opcodes 01 and 02 are reserved and never sent.
`timescale 1ns/1ns
`default_nettype none
module dcd_host #(
    parameter int ADDR_W = dcd_pkg::REG_AW
) (
    input wire logic CLK_IN, // 125 MHz clock
    input wire logic RSTN_IN, // Synchronous reset, active low
    input wire logic [ADDR_W-1:0] ADDR_IN, // Register address
    input wire logic [dcd_pkg::REG_DW-1:0] WDATA_IN, // Write data
    input wire logic WR_IN, // Write strobe
    input wire logic RD_IN, // Read strobe
    output logic [dcd_pkg::REG_DW-1:0] RDATA_OUT, // Read data, next cycle
    output logic [7:0] TX_DATA_OUT, // Command byte to the controller
    output logic TX_VALID_OUT, // Byte offered
    input wire logic TX_READY_IN // Controller takes the byte
);
    import dcd_pkg::*;

    if (ADDR_W < REG_AW) begin : g_chk
        $error("ADDR_W too narrow for the register map");
    end

    dcd_regs_t q;
    dcd_regs_t n;
    logic [7:0] blk [0:13];
    logic c0, c7, is_fmt, has_sect, has_cyl, has_cnt, drv_only, has_ctl;
    logic ecc_opt, is_char, legal, ilv_ok, step_ok, start_ok, hs;
    logic [3:0] last;

    // class and opcode split of byte 0.
    assign c0 = q.cls == CLS_DISK;
    assign c7 = q.cls == CLS_DIAG;
    assign is_fmt = c0 && (q.op == OP_FMT_DRV || q.op == OP_FMT_TRK || q.op == OP_FMT_BAD);
    // read, write and the long forms carry a sector number.
    assign has_sect = (c0 && (q.op == OP_READ || q.op == OP_WRITE))
        || (c7 && (q.op == OP_LONG_RD || q.op == OP_LONG_WR));
    assign has_cyl = has_sect || is_fmt || (c0 && (q.op == OP_VERIFY || q.op == OP_SEEK));
    assign has_cnt = has_sect || (c0 && q.op == OP_VERIFY);
    // these send only the drive bit and control byte.
    assign drv_only = (c0 && (q.op == OP_TEST || q.op == OP_RECAL || q.op == OP_SENSE))
        || (c7 && q.op == OP_DRV_DIAG);
    assign has_ctl = has_cyl || drv_only;
    assign ecc_opt = c0 && (q.op == OP_READ || q.op == OP_VERIFY);
    assign is_char = c0 && q.op == OP_INIT;
    // reserved codes are refused rather than sent.
    assign legal = (c0 && q.op != OP_RSV2 && q.op != OP_RSV9 && q.op <= OP_BUF_WR)
        || (c7 && (q.op == OP_RAM_DIAG || (q.op >= OP_DRV_DIAG && q.op <= OP_LONG_WR)));
    // interleave range is checked before a format goes out.
    assign ilv_ok = !is_fmt || (q.count >= ILV_MIN && q.count <= ILV_MAX);
    // the unassigned step codes are not passed to the drive.
    assign step_ok = !has_ctl || q.step == '0 || q.step > STEP_NA_MAX;
    assign start_ok = legal && ilv_ok && step_ok;
    assign last = is_char ? CHAR_LAST : BLOCK_LAST;
    assign hs = q.tx_valid && TX_READY_IN;

    always_comb begin
        // ignored bytes go out as zero.
        for (int i = 0; i < 14; i++) begin
            blk[i] = '0;
        end
        blk[0] = {q.cls, q.op};
        // drive bit over the head number, two zero bits on top.
        if (has_cyl) begin
            blk[1] = {2'b00, q.drive, q.head};
        end else if (drv_only) begin
            blk[1] = {2'b00, q.drive, 5'b0_0000};
        end
        // seek, verify and format clear the sector bits.
        if (has_cyl) begin
            blk[2] = {q.cyl[9:8], has_sect ? q.sect : 6'b00_0000};
            blk[3] = q.cyl[7:0];
        end
        // format interleave with its top two bits held low.
        if (is_fmt) begin
            blk[4] = {2'b00, q.count[5:0]};
        end else if (has_cnt) begin
            blk[4] = q.count;
        end
        // retry bit always, reread bit only for reads and verify.
        if (has_ctl) begin
            blk[5] = {q.retry_off, ecc_opt & q.reread_off, 3'b000, q.step};
        end
        // parameters high byte first, in the documented order.
        blk[6] = q.maxcyl[15:8];
        blk[7] = q.maxcyl[7:0];
        blk[8] = q.maxhead;
        blk[9] = q.rwc[15:8];
        blk[10] = q.rwc[7:0];
        blk[11] = q.precomp[15:8];
        blk[12] = q.precomp[7:0];
        blk[13] = q.ecclen;
    end

    always_comb begin
        n = q;
        n.rdata = '0;
        if (RD_IN) begin
            unique case (ADDR_IN[REG_AW-1:0])
                OFF_CMD: n.rdata = {8'h00, q.cls, q.op};
                OFF_ADDR: n.rdata = {10'h000, q.drive, q.head};
                OFF_CYL: n.rdata = {6'h00, q.cyl};
                OFF_SECT: n.rdata = {10'h000, q.sect};
                OFF_COUNT: n.rdata = {8'h00, q.count};
                OFF_CTRL: n.rdata = {8'h00, q.retry_off, q.reread_off, 3'b000, q.step};
                OFF_MAXCYL: n.rdata = q.maxcyl;
                OFF_MAXHEAD: n.rdata = {8'h00, q.maxhead};
                OFF_RWC: n.rdata = q.rwc;
                OFF_PRECOMP: n.rdata = q.precomp;
                OFF_ECCLEN: n.rdata = {8'h00, q.ecclen};
                OFF_GO: begin
                    n.rdata[ST_BUSY] = q.st == DCD_SEND;
                    n.rdata[ST_DONE] = q.done;
                    n.rdata[ST_REFUSED] = q.refused;
                end
                default: n.rdata = '0;
            endcase
        end
        // Writes are ignored while a block is on the wire, so the bytes stay coherent.
        if (WR_IN && q.st == DCD_IDLE) begin
            unique case (ADDR_IN[REG_AW-1:0])
                OFF_CMD: {n.cls, n.op} = WDATA_IN[7:0];
                OFF_ADDR: {n.drive, n.head} = WDATA_IN[5:0];
                OFF_CYL: n.cyl = WDATA_IN[9:0];
                OFF_SECT: n.sect = WDATA_IN[5:0];
                OFF_COUNT: n.count = WDATA_IN[7:0];
                OFF_CTRL: begin
                    n.retry_off = WDATA_IN[7];
                    n.reread_off = WDATA_IN[6];
                    n.step = WDATA_IN[2:0];
                end
                OFF_MAXCYL: n.maxcyl = WDATA_IN;
                OFF_MAXHEAD: n.maxhead = WDATA_IN[7:0];
                OFF_RWC: n.rwc = WDATA_IN;
                OFF_PRECOMP: n.precomp = WDATA_IN;
                OFF_ECCLEN: n.ecclen = WDATA_IN[7:0];
                OFF_GO: begin
                    n.done = 1'b0;
                    n.refused = !start_ok;
                    // the block starts with byte 0.
                    if (start_ok) begin
                        n.st = DCD_SEND;
                        n.idx = '0;
                        n.tx_data = blk[0];
                        n.tx_valid = 1'b1;
                    end
                end
                default: ;
            endcase
        end
        if (q.st == DCD_SEND && hs) begin
            // the characteristics block runs on through eight parameters.
            if (q.idx == last) begin
                n.st = DCD_IDLE;
                n.tx_valid = 1'b0;
                n.done = 1'b1;
            end else begin
                n.idx = q.idx + 4'h1;
                n.tx_data = blk[q.idx + 4'h1];
            end
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (!RSTN_IN) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign RDATA_OUT = q.rdata;
    assign TX_DATA_OUT = q.tx_data;
    assign TX_VALID_OUT = q.tx_valid;

    property p_first;
        @(posedge CLK_IN) disable iff (!RSTN_IN)
        (q.st == DCD_IDLE && n.st == DCD_SEND) |=> (q.idx == 4'h0 && TX_DATA_OUT == {q.cls, q.op});
    endproperty
    a_first: assert property (p_first) else $error("Block did not open with byte 0");

    property p_step;
        @(posedge CLK_IN) disable iff (!RSTN_IN)
        (hs && q.idx != last) |=> (q.idx == $past(q.idx) + 4'h1 && TX_VALID_OUT);
    endproperty
    a_step: assert property (p_step) else $error("Byte order broken");

    property p_rsv;
        @(posedge CLK_IN) disable iff (!RSTN_IN)
        (TX_VALID_OUT && q.idx == 4'h0) |-> !(TX_DATA_OUT inside {8'h02, 8'h09, 8'hE1, 8'hE2});
    endproperty
    a_rsv: assert property (p_rsv) else $error("Reserved code sent");

    property p_b1;
        @(posedge CLK_IN) disable iff (!RSTN_IN)
        (TX_VALID_OUT && q.idx == 4'h1 && has_cyl) |-> TX_DATA_OUT == {2'b00, q.drive, q.head};
    endproperty
    a_b1: assert property (p_b1) else $error("Byte 1 layout wrong");

    property p_ilv;
        @(posedge CLK_IN) disable iff (!RSTN_IN)
        (TX_VALID_OUT && q.idx == 4'h4 && is_fmt)
            |-> (TX_DATA_OUT[7:6] == 2'b00 && TX_DATA_OUT >= ILV_MIN && TX_DATA_OUT <= ILV_MAX);
    endproperty
    a_ilv: assert property (p_ilv) else $error("Interleave byte out of range");

    property p_sect;
        @(posedge CLK_IN) disable iff (!RSTN_IN)
        (TX_VALID_OUT && q.idx == 4'h2 && has_cyl && !has_sect) |-> TX_DATA_OUT[5:0] == 6'h00;
    endproperty
    a_sect: assert property (p_sect) else $error("Sector bits not cleared");

    property p_char;
        @(posedge CLK_IN) disable iff (!RSTN_IN)
        (hs && is_char && q.idx == BLOCK_LAST) |=> (TX_VALID_OUT && TX_DATA_OUT == q.maxcyl[15:8]);
    endproperty
    a_char: assert property (p_char) else $error("Parameters did not follow block");

    property p_prm;
        @(posedge CLK_IN) disable iff (!RSTN_IN)
        (TX_VALID_OUT && is_char && q.idx == 4'h8) |-> TX_DATA_OUT == q.maxhead;
    endproperty
    a_prm: assert property (p_prm) else $error("Parameter order wrong");

    property p_ign;
        @(posedge CLK_IN) disable iff (!RSTN_IN)
        (TX_VALID_OUT && is_char && q.idx != 4'h0 && q.idx <= BLOCK_LAST) |-> TX_DATA_OUT == 8'h00;
    endproperty
    a_ign: assert property (p_ign) else $error("Ignored byte not zero");

    property p_ecc;
        @(posedge CLK_IN) disable iff (!RSTN_IN)
        (TX_VALID_OUT && q.idx == 4'h5 && !ecc_opt) |-> !TX_DATA_OUT[6];
    endproperty
    a_ecc: assert property (p_ecc) else $error("Reread bit on a non-read");

    property p_end;
        @(posedge CLK_IN) disable iff (!RSTN_IN)
        (hs && q.idx == last) |=> (!TX_VALID_OUT && q.done && q.st == DCD_IDLE);
    endproperty
    a_end: assert property (p_end) else $error("Block did not end after last byte");

    property p_drv;
        @(posedge CLK_IN) disable iff (!RSTN_IN)
        (TX_VALID_OUT && q.idx == 4'h1 && drv_only) |-> TX_DATA_OUT == {2'b00, q.drive, 5'h00};
    endproperty
    a_drv: assert property (p_drv) else $error("Drive byte wrong");

    property p_zero;
        @(posedge CLK_IN) disable iff (!RSTN_IN)
        (TX_VALID_OUT && q.idx >= 4'h2 && q.idx <= 4'h4 && drv_only) |-> TX_DATA_OUT == 8'h00;
    endproperty
    a_zero: assert property (p_zero) else $error("Unused address byte not zero");

    property p_b2;
        @(posedge CLK_IN) disable iff (!RSTN_IN)
        (TX_VALID_OUT && q.idx == 4'h2 && has_sect) |-> TX_DATA_OUT == {q.cyl[9:8], q.sect};
    endproperty
    a_b2: assert property (p_b2) else $error("Sector byte wrong");

    property p_b3;
        @(posedge CLK_IN) disable iff (!RSTN_IN)
        (TX_VALID_OUT && q.idx == 4'h3 && has_cyl) |-> TX_DATA_OUT == q.cyl[7:0];
    endproperty
    a_b3: assert property (p_b3) else $error("Cylinder low byte wrong");

    property p_cnt;
        @(posedge CLK_IN) disable iff (!RSTN_IN)
        (TX_VALID_OUT && q.idx == 4'h4 && has_cnt) |-> TX_DATA_OUT == q.count;
    endproperty
    a_cnt: assert property (p_cnt) else $error("Block count byte wrong");

    property p_ctl;
        @(posedge CLK_IN) disable iff (!RSTN_IN)
        (TX_VALID_OUT && q.idx == 4'h5 && has_ctl)
            |-> (TX_DATA_OUT[7] == q.retry_off && TX_DATA_OUT[5:0] == {3'b000, q.step});
    endproperty
    a_ctl: assert property (p_ctl) else $error("Control byte wrong");

    property p_rrd;
        @(posedge CLK_IN) disable iff (!RSTN_IN)
        (TX_VALID_OUT && q.idx == 4'h5 && ecc_opt) |-> TX_DATA_OUT[6] == q.reread_off;
    endproperty
    a_rrd: assert property (p_rrd) else $error("Reread option lost");

    property p_last;
        @(posedge CLK_IN) disable iff (!RSTN_IN)
        (TX_VALID_OUT && is_char && q.idx == CHAR_LAST) |-> TX_DATA_OUT == q.ecclen;
    endproperty
    a_last: assert property (p_last) else $error("Last parameter wrong");

    property p_ref;
        @(posedge CLK_IN) disable iff (!RSTN_IN)
        (WR_IN && ADDR_IN[REG_AW-1:0] == OFF_GO && q.st == DCD_IDLE && !legal)
            |=> (q.refused && !TX_VALID_OUT);
    endproperty
    a_ref: assert property (p_ref) else $error("Reserved command not refused");

    property p_hold;
        @(posedge CLK_IN) disable iff (!RSTN_IN)
        (TX_VALID_OUT && !TX_READY_IN) |=> (TX_VALID_OUT && $stable(TX_DATA_OUT) && $stable(q.idx));
    endproperty
    a_hold: assert property (p_hold) else $error("Offered byte changed before taken");

    c_char: cover property (@(posedge CLK_IN) disable iff (!RSTN_IN)
        hs && is_char && q.idx == CHAR_LAST);
    c_read: cover property (@(posedge CLK_IN) disable iff (!RSTN_IN)
        hs && has_sect && q.idx == BLOCK_LAST);
    c_ref: cover property (@(posedge CLK_IN) disable iff (!RSTN_IN)
        WR_IN && ADDR_IN[REG_AW-1:0] == OFF_GO && q.st == DCD_IDLE && !start_ok);
    c_fmt: cover property (@(posedge CLK_IN) disable iff (!RSTN_IN)
        hs && is_fmt && q.idx == BLOCK_LAST);
    c_hold: cover property (@(posedge CLK_IN) disable iff (!RSTN_IN)
        TX_VALID_OUT && !TX_READY_IN);
endmodule
`default_nettype wire

// [hdl/dcd_pkg.sv]
package dcd_pkg;
    localparam int REG_AW = 4;
    localparam int REG_DW = 16;
    localparam logic [3:0] OFF_CMD = 4'h0;
    localparam logic [3:0] OFF_ADDR = 4'h1;
    localparam logic [3:0] OFF_CYL = 4'h2;
    localparam logic [3:0] OFF_SECT = 4'h3;
    localparam logic [3:0] OFF_COUNT = 4'h4;
    localparam logic [3:0] OFF_CTRL = 4'h5;
    localparam logic [3:0] OFF_MAXCYL = 4'h6;
    localparam logic [3:0] OFF_MAXHEAD = 4'h7;
    localparam logic [3:0] OFF_RWC = 4'h8;
    localparam logic [3:0] OFF_PRECOMP = 4'h9;
    localparam logic [3:0] OFF_ECCLEN = 4'hA;
    localparam logic [3:0] OFF_GO = 4'hB;
    localparam logic [2:0] CLS_DISK = 3'h0;
    localparam logic [2:0] CLS_DIAG = 3'h7;
    localparam logic [4:0] OP_TEST = 5'h00;
    localparam logic [4:0] OP_RECAL = 5'h01;
    localparam logic [4:0] OP_RSV2 = 5'h02;
    localparam logic [4:0] OP_SENSE = 5'h03;
    localparam logic [4:0] OP_FMT_DRV = 5'h04;
    localparam logic [4:0] OP_VERIFY = 5'h05;
    localparam logic [4:0] OP_FMT_TRK = 5'h06;
    localparam logic [4:0] OP_FMT_BAD = 5'h07;
    localparam logic [4:0] OP_READ = 5'h08;
    localparam logic [4:0] OP_RSV9 = 5'h09;
    localparam logic [4:0] OP_WRITE = 5'h0A;
    localparam logic [4:0] OP_SEEK = 5'h0B;
    localparam logic [4:0] OP_INIT = 5'h0C;
    localparam logic [4:0] OP_BUF_WR = 5'h0F;
    localparam logic [4:0] OP_RAM_DIAG = 5'h00;
    localparam logic [4:0] OP_DRV_DIAG = 5'h03;
    localparam logic [4:0] OP_INT_DIAG = 5'h04;
    localparam logic [4:0] OP_LONG_RD = 5'h05;
    localparam logic [4:0] OP_LONG_WR = 5'h06;
    localparam logic [3:0] BLOCK_LAST = 4'h5;
    localparam logic [3:0] CHAR_LAST = 4'hD;
    localparam logic [7:0] ILV_MIN = 8'h01;
    localparam logic [7:0] ILV_MAX = 8'h10;
    localparam logic [2:0] STEP_NA_MAX = 3'h3;
    localparam int ST_BUSY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_REFUSED = 2;
    typedef enum logic {DCD_IDLE, DCD_SEND} dcd_state_t;
    typedef struct packed {
        dcd_state_t st;
        logic [3:0] idx;
        logic [7:0] tx_data;
        logic tx_valid;
        logic [15:0] rdata;
        logic refused;
        logic done;
        logic [2:0] cls;
        logic [4:0] op;
        logic drive;
        logic [4:0] head;
        logic [9:0] cyl;
        logic [5:0] sect;
        logic [7:0] count;
        logic retry_off;
        logic reread_off;
        logic [2:0] step;
        logic [15:0] maxcyl;
        logic [7:0] maxhead;
        logic [15:0] rwc;
        logic [15:0] precomp;
        logic [7:0] ecclen;
    } dcd_regs_t;
endpackage

// [verif/dcd_ctrl_model.sv]
`timescale 1ns/1ns
`default_nettype none
module dcd_ctrl_model (
    input wire logic clk_in, // System clock
    input wire logic rstn_in, // Synchronous reset, active low
    input wire logic [7:0] data_in, // Offered command byte
    input wire logic valid_in, // Byte offered
    input wire logic stall_in, // Bench asks for a slow answer
    output logic ready_out // Byte taken at this edge
);
    logic [7:0] got [$];

    // data phases are not modelled here; long commands are checked by their block.
    assign ready_out = !stall_in;

    // keeps arrival order
    // Every byte is stored raw so that the bench decodes class and opcode itself.
    always @(posedge clk_in) begin
        if (!rstn_in) begin
            got.delete();
        end else if (valid_in && ready_out) begin
            got.push_back(data_in);
        end
    end
endmodule
`default_nettype wire

// [verif/disk_command_decoder_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module disk_command_decoder_tb;
    import dcd_pkg::*;
    localparam logic [15:0] MASK [11] = '{16'h00ff, 16'h003f, 16'h03ff, 16'h003f, 16'h00ff,
        16'h00c7, 16'hffff, 16'h00ff, 16'hffff, 16'hffff, 16'h00ff};
    logic clk, rstn, wr, rd, stall, slow, ready, valid;
    logic [3:0] addr;
    logic [15:0] wdata, rdata, v;
    logic [7:0] txd;
    logic [31:0] seed;
    logic [15:0] r [11];
    logic [7:0] exp_q [$];
    int mismatches = 0;
    int compares = 0;
    int cycles = 0;
    bit refuse;

    dcd_host dut (.CLK_IN(clk), .RSTN_IN(rstn), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr),
        .RD_IN(rd), .RDATA_OUT(rdata), .TX_DATA_OUT(txd), .TX_VALID_OUT(valid),
        .TX_READY_IN(ready));
    dcd_ctrl_model ctrl (.clk_in(clk), .rstn_in(rstn), .data_in(txd), .valid_in(valid),
        .stall_in(stall), .ready_out(ready));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic complete_run();
        $display("counts: %0d compares, %0d mismatches", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        chk({8'h00, got}, {8'h00, exp});
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        addr <= a;
        wdata <= d;
        rd <= 1'b0;
        wr <= 1'b1;
        @(posedge clk);
    endtask

    task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
        addr <= a;
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
        @(posedge clk);
    endtask

    // Reference decoder: builds the byte stream that the controller must receive.
    task automatic build();
        logic [2:0] c;
        logic [4:0] o;
        logic [7:0] n;
        bit fmt, sec, cyl, cnt, drv, b5;
        c = r[0][7:5];
        o = r[0][4:0];
        n = r[4][7:0];
        fmt = c == 0 && o inside {4, 6, 7};
        sec = (c == 0 && o inside {8, 10}) || (c == 7 && o inside {5, 6});
        cyl = sec || fmt || (c == 0 && o inside {5, 11});
        cnt = sec || (c == 0 && o == 5);
        drv = (c == 0 && o inside {0, 1, 3}) || (c == 7 && o == 3);
        b5 = (c == 0 && o <= 11) || (c == 7 && o inside {3, 5, 6});
        refuse = !((c == 0 && o <= 15 && o != 2 && o != 9) || (c == 7 && o <= 6 && o > 2)
            || (c == 7 && o == 0));
        if ((fmt && (n < 1 || n > 16)) || (b5 && r[5][2:0] inside {[1:3]})) begin
            refuse = 1'b1;
        end
        exp_q.delete();
        if (refuse) begin
            return;
        end
        exp_q.push_back(r[0][7:0]);
        exp_q.push_back(cyl ? {2'b00, r[1][5:0]} : drv ? {2'b00, r[1][5], 5'h00} : 8'h00);
        exp_q.push_back(sec ? {r[2][9:8], r[3][5:0]} : cyl ? {r[2][9:8], 6'h00} : 8'h00);
        exp_q.push_back(cyl ? r[2][7:0] : 8'h00);
        exp_q.push_back(cnt ? n : fmt ? {2'b00, n[5:0]} : 8'h00);
        exp_q.push_back(b5 ? {r[5][7], r[5][6] && c == 0 && o inside {5, 8}, 3'b000, r[5][2:0]}
            : 8'h00);
        if (c == 0 && o == 12) begin
            exp_q.push_back(r[6][15:8]);
            exp_q.push_back(r[6][7:0]);
            exp_q.push_back(r[7][7:0]);
            exp_q.push_back(r[8][15:8]);
            exp_q.push_back(r[8][7:0]);
            exp_q.push_back(r[9][15:8]);
            exp_q.push_back(r[9][7:0]);
            exp_q.push_back(r[10][7:0]);
        end
    endtask

    task automatic run_cmd();
        int n;
        for (int i = 0; i < 11; i++) begin
            wr_reg(4'(i), r[i]);
        end
        build();
        ctrl.got.delete();
        wr_reg(OFF_GO, 16'(rnd()));
        // A command write while busy must not disturb the block in flight.
        if (!refuse) begin
            wr_reg(OFF_CMD, ~r[0]);
        end
        n = 0;
        do begin
            rd_reg(OFF_GO, v);
            n++;
        end while (v[0] !== 1'b0 && n < 100);
        chk(v, refuse ? 16'h0004 : 16'h0002);
        chk(16'(ctrl.got.size()), 16'(exp_q.size()));
        foreach (exp_q[i]) begin
            if (i < ctrl.got.size()) begin
                case (i)
                    0: chk_byte(ctrl.got[i], exp_q[i]);
                    1: chk_byte(ctrl.got[i], exp_q[i]);
                    2, 3, 4: chk_byte(ctrl.got[i], exp_q[i]);
                    5: chk_byte(ctrl.got[i], exp_q[i]);
                    default: chk_byte(ctrl.got[i], exp_q[i]);
                endcase
            end
        end
        rd_reg(OFF_CMD, v);
        chk(v, r[0] & MASK[0]);
    endtask

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk) begin
        stall <= slow && (cycles % 3 != 0);
        cycles <= cycles + 1;
        if (cycles >= 40000) begin
            mismatches++;
            complete_run();
        end
    end

    initial begin
        seed = 32'h35e8_4454;
        {rstn, wr, rd, slow} = '0;
        addr = '0;
        wdata = '0;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        foreach (r[i]) r[i] = 16'(rnd());
        for (int i = 0; i < 16; i++) begin
            rd_reg(4'(i), v);
            chk(v, 16'h0000);
            if (i != 11) wr_reg(4'(i), i < 11 ? r[i] : 16'hffff);
        end
        for (int i = 0; i < 16; i++) begin
            rd_reg(4'(i), v);
            if (i != 11) chk(v, i < 11 ? r[i] & MASK[i] : 16'h0000);
        end
        $display("test registers done");
        for (int k = 0; k < 96; k++) begin
            slow <= k[0];
            foreach (r[i]) r[i] = 16'(rnd());
            r[4] = 16'(rnd() % 20);
            if (r[5][2:0] inside {[1:3]} && rnd() % 4 != 0) r[5][2] = 1'b1;
            if (k < 64) r[0] = {8'h00, k[5] ? CLS_DIAG : CLS_DISK, 5'(k)};
            run_cmd();
        end
        $display("test commands done");
        complete_run();
    end
endmodule
`default_nettype wire
